// File: verilog/swv_consts.svh
`ifndef SWV_CONSTS_SVH
`define SWV_CONSTS_SVH

// Pipeline stage numbers.
`define SWV_NSTAGE 8
`define SWV_ST_MFC 4
`define SWV_ST_FETCHVIEW 4
`define SWV_ST_TLBSRC 5
`define SWV_ST_MTC 7
`define SWV_ST_LAST 8

// Control register indices.
`define SWV_R_INDEX 3'h0
`define SWV_R_ENTRYLO 3'h1
`define SWV_R_ENTRYHI 3'h2
`define SWV_R_STATUS 3'h3
`define SWV_R_EPC 3'h4

// Status field positions.
`define SWV_EXL_BIT 1
`define SWV_ERL_BIT 2

// Saturation of the spacing counter.
`define SWV_GAP_MAX 4'hf
`endif

// File: verilog/swv_pkg.sv
package swv_pkg;
  typedef enum logic [2:0] {
    SWV_OP_NOP = 3'h0,
    SWV_OP_MTC = 3'h1,
    SWV_OP_MFC = 3'h2,
    SWV_OP_TLB_WRITE_RANDOM = 3'h3,
    SWV_OP_EXCEPTION_RETURN = 3'h4
  } swv_op_t;

  typedef struct packed {
    logic vld;
    swv_op_t op;
    logic [2:0] rsel;
    logic [31:0] data;
    logic exc;
  } swv_slot_t;

  typedef struct packed {
    logic vld;
    logic [31:0] data;
  } swv_rd_t;

  typedef struct packed {
    logic vld;
    logic [31:0] hi;
    logic [31:0] lo;
  } swv_tlbw_t;
endpackage

// File: verilog/swv_hazard_chk.sv
`include "swv_consts.svh"
module swv_hazard_chk (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pair to check.
  input wire logic i_check,
  input wire logic [3:0] i_avail,
  input wire logic [3:0] i_use,
  input wire logic [3:0] i_between,
  // Result.
  output logic o_hazard
);
  typedef struct packed {
    logic hazard;
  } swv_chk_state_t;

  swv_chk_state_t q;
  swv_chk_state_t d;

  // Instructions needed between the pair; zero when no hazard exists.
  function automatic logic [3:0] req_gap(input logic [3:0] avail, input logic [3:0] use_st);
    logic [4:0] sum;
    sum = {1'b0, use_st} + 5'h01;
    req_gap = ({1'b0, avail} > sum) ? 4'({1'b0, avail} - sum) : 4'h0;
  endfunction

  always_comb begin
    d = q;
    if (i_check) begin
      d.hazard = i_between < req_gap(i_avail, i_use);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_hazard = q.hazard;

  back_to_back_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_check && ({1'b0, i_avail} <= ({1'b0, i_use} + 5'h01))) |=> !o_hazard)
    else $error("Pair without hazard was flagged.");
endmodule

// File: verilog/swv_pipe_ctl.sv
`include "swv_consts.svh"
module swv_pipe_ctl (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Instruction issue and integer interlock.
  input swv_pkg::swv_slot_t i_issue,
  input wire logic i_gpr_busy,
  // Results.
  output logic o_stall,
  output swv_pkg::swv_rd_t o_rd,
  output swv_pkg::swv_tlbw_t o_tlb_wr,
  output logic o_tlb_src_changed,
  output logic [31:0] o_status,
  output logic [31:0] o_fetch_status,
  output logic o_hazard
);
  import swv_pkg::*;

  typedef struct packed {
    swv_slot_t [`SWV_NSTAGE:1] pipe;
    logic [7:0][31:0] regs;
    logic [31:0] tlb_hi;
    logic [31:0] tlb_lo;
    logic src_bad;
    logic [3:0] since_mtc;
    logic stall;
    swv_rd_t rd;
    swv_tlbw_t tlbw;
    logic src_changed;
    logic [31:0] fetch_status;
    logic chk;
    logic [3:0] chk_use;
    logic [3:0] chk_between;
  } swv_state_t;

  swv_state_t q;
  swv_state_t d;
  logic adv;
  logic hide_lvl;

  function automatic logic is_op(input swv_slot_t s, input swv_op_t op);
    is_op = s.vld && (s.op == op);
  endfunction

  // Control state as a reader sees it: a write sitting in stage 7 is already visible.
  function automatic logic [31:0] ctl_read(input swv_state_t s, input logic [2:0] r);
    ctl_read = s.regs[r];
    if (is_op(s.pipe[`SWV_ST_MTC], SWV_OP_MTC) && (s.pipe[`SWV_ST_MTC].rsel == r)) begin
      ctl_read = s.pipe[`SWV_ST_MTC].data;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Only an integer interlock freezes the pipeline; control writes never do.
  assign adv = !i_gpr_busy;

  always_comb begin
    d = q;
    hide_lvl = 1'b0;
    d.stall = i_gpr_busy;
    d.rd.vld = 1'b0;
    d.tlbw.vld = 1'b0;
    d.chk = 1'b0;
    if (adv) begin
      // Every slot moves one stage per cycle.
      for (int s = `SWV_NSTAGE; s >= 2; s--) begin
        d.pipe[s] = q.pipe[s - 1];
      end
      d.pipe[1] = i_issue;
      if (i_issue.vld) begin
        d.chk = (i_issue.op == SWV_OP_TLB_WRITE_RANDOM) || (i_issue.op == SWV_OP_MFC);
        d.chk_use = (i_issue.op == SWV_OP_TLB_WRITE_RANDOM) ? 4'(`SWV_ST_TLBSRC) : 4'(`SWV_ST_MFC);
        d.chk_between = q.since_mtc;
        if (i_issue.op == SWV_OP_MTC) begin
          d.since_mtc = 4'h0;
        end else if (q.since_mtc != `SWV_GAP_MAX) begin
          d.since_mtc = q.since_mtc + 4'h1;
        end
      end
      // Reads of control state happen without waiting for pending writes.
      if (is_op(q.pipe[`SWV_ST_MFC], SWV_OP_MFC)) begin
        d.rd.vld = 1'b1;
        d.rd.data = ctl_read(q, q.pipe[`SWV_ST_MFC].rsel);
      end
      if (is_op(q.pipe[`SWV_ST_TLBSRC], SWV_OP_TLB_WRITE_RANDOM)) begin
        d.tlb_hi = ctl_read(q, `SWV_R_ENTRYHI);
        d.tlb_lo = ctl_read(q, `SWV_R_ENTRYLO);
        d.src_bad = 1'b0;
      end
      if (is_op(q.pipe[`SWV_ST_MTC], SWV_OP_MTC)) begin
        d.regs[q.pipe[`SWV_ST_MTC].rsel] = q.pipe[`SWV_ST_MTC].data;
        // A source moving under a random TLB write in stages 6 to 8 is reported.
        if (((q.pipe[`SWV_ST_MTC].rsel == `SWV_R_ENTRYHI) ||
             (q.pipe[`SWV_ST_MTC].rsel == `SWV_R_ENTRYLO)) &&
            (is_op(q.pipe[6], SWV_OP_TLB_WRITE_RANDOM) || is_op(q.pipe[7], SWV_OP_TLB_WRITE_RANDOM) ||
             is_op(q.pipe[8], SWV_OP_TLB_WRITE_RANDOM))) begin
          d.src_bad = 1'b1;
        end
      end
      if (is_op(q.pipe[`SWV_ST_LAST], SWV_OP_TLB_WRITE_RANDOM)) begin
        d.tlbw.vld = 1'b1;
        d.tlbw.hi = q.tlb_hi;
        d.tlbw.lo = q.tlb_lo;
      end
      // Exceptions write control state at the last stage, also unlocked.
      if (q.pipe[`SWV_ST_LAST].vld && q.pipe[`SWV_ST_LAST].exc) begin
        d.regs[`SWV_R_EPC] = q.pipe[`SWV_ST_LAST].data;
        d.regs[`SWV_R_STATUS][`SWV_EXL_BIT] = 1'b1;
      end else if (is_op(q.pipe[`SWV_ST_LAST], SWV_OP_EXCEPTION_RETURN)) begin
        d.regs[`SWV_R_STATUS][`SWV_EXL_BIT] = 1'b0;
        d.regs[`SWV_R_STATUS][`SWV_ERL_BIT] = 1'b0;
      end
    end
    d.src_changed = d.src_bad;
    // Fetch sees the level bits cleared once a return has reached stage 4.
    for (int s = `SWV_ST_FETCHVIEW; s <= `SWV_NSTAGE; s++) begin
      if (is_op(q.pipe[s], SWV_OP_EXCEPTION_RETURN) && !q.pipe[s].exc) begin
        hide_lvl = 1'b1;
      end
    end
    d.fetch_status = q.regs[`SWV_R_STATUS];
    if (hide_lvl) begin
      d.fetch_status[`SWV_EXL_BIT] = 1'b0;
      d.fetch_status[`SWV_ERL_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spacing checker against the most recent control register write.
  swv_hazard_chk u_chk (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_check(q.chk),
    .i_avail(4'(`SWV_ST_MTC)),
    .i_use(q.chk_use),
    .i_between(q.chk_between),
    .o_hazard(o_hazard)
  );

  assign o_stall = q.stall;
  assign o_rd = q.rd;
  assign o_tlb_wr = q.tlbw;
  assign o_tlb_src_changed = q.src_changed;
  assign o_status = q.regs[`SWV_R_STATUS];
  assign o_fetch_status = q.fetch_status;

  ////////////////////////////////////////////////////////////////////////////
  swv_slot_t w3;
  swv_slot_t w4;
  swv_slot_t w5;
  logic [31:0] view_hi;
  logic [31:0] view_lo;
  assign w4 = q.pipe[`SWV_ST_MFC];
  assign view_hi = ctl_read(q, `SWV_R_ENTRYHI);
  assign view_lo = ctl_read(q, `SWV_R_ENTRYLO);
  swv_slot_t w7;
  swv_slot_t w8;
  assign w3 = q.pipe[3];
  assign w5 = q.pipe[`SWV_ST_TLBSRC];
  assign w7 = q.pipe[`SWV_ST_MTC];
  assign w8 = q.pipe[`SWV_ST_LAST];

  stall_freeze_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_gpr_busy |=> (q.pipe == $past(q.pipe)) && o_stall)
    else $error("Pipeline moved during an interlock.");

  no_ctl_stall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_gpr_busy && is_op(w4, SWV_OP_MFC) &&
     (is_op(q.pipe[5], SWV_OP_MTC) || is_op(q.pipe[6], SWV_OP_MTC))) |=> o_rd.vld && !o_stall)
    else $error("Control read waited for a pending write.");

  mtc_commit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && w7.vld && (w7.op == SWV_OP_MTC) && !(w8.vld && (w8.exc || (w8.op == SWV_OP_EXCEPTION_RETURN))))
      |=> (q.regs[$past(w7.rsel)] == $past(w7.data)))
    else $error("Control write missed stage 7.");

  tlb_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && w5.vld && (w5.op == SWV_OP_TLB_WRITE_RANDOM)) |=>
      (q.tlb_hi == $past(view_hi)) && (q.tlb_lo == $past(view_lo)) && !q.src_bad)
    else $error("TLB sources not captured in stage 5.");

  mtc_bypass_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && is_op(w4, SWV_OP_MFC) && is_op(w7, SWV_OP_MTC) && (w4.rsel == w7.rsel)) |=>
      (o_rd.data == $past(w7.data)))
    else $error("Read in stage 4 missed the stage 7 value.");

  src_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && is_op(w7, SWV_OP_MTC) && is_op(q.pipe[6], SWV_OP_TLB_WRITE_RANDOM) &&
     ((w7.rsel == `SWV_R_ENTRYHI) || (w7.rsel == `SWV_R_ENTRYLO))) |=> o_tlb_src_changed)
    else $error("Moved TLB source was not reported.");

  exc_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && w8.vld && w8.exc) |=> o_status[`SWV_EXL_BIT] && (q.regs[`SWV_R_EPC] == $past(w8.data)))
    else $error("Exception did not write control state.");

  exception_return_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && w8.vld && !w8.exc && (w8.op == SWV_OP_EXCEPTION_RETURN)) |=>
      !o_status[`SWV_EXL_BIT] && !o_status[`SWV_ERL_BIT])
    else $error("Return did not clear level bits.");

  fetch_view_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (is_op(q.pipe[`SWV_ST_FETCHVIEW], SWV_OP_EXCEPTION_RETURN) && !q.pipe[`SWV_ST_FETCHVIEW].exc) |=>
      !o_fetch_status[`SWV_EXL_BIT])
    else $error("Fetch saw level bit during return.");

  stage_walk_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (adv && w3.vld) |=> (q.pipe[4] == $past(w3)))
    else $error("Slot skipped a stage.");

  mtc_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    adv && is_op(w7, SWV_OP_MTC));
  tlbw_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_tlb_wr.vld);
  exception_return_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    adv && is_op(w8, SWV_OP_EXCEPTION_RETURN));
  hazard_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_hazard);
  bypass_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    adv && is_op(w4, SWV_OP_MFC) && is_op(w7, SWV_OP_MTC));
endmodule

// File: test/swv_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import swv_pkg::*;
  logic i_clk;
  logic i_sys_rst;
  logic i_gpr_busy;
  swv_slot_t i_issue;
  logic o_stall;
  swv_rd_t o_rd;
  swv_tlbw_t o_tlb_wr;
  logic o_tlb_src_changed;
  logic [31:0] o_status;
  logic [31:0] o_fetch_status;
  logic o_hazard;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  swv_pipe_ctl i_dut (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_issue(i_issue),
    .i_gpr_busy(i_gpr_busy),
    .o_stall(o_stall),
    .o_rd(o_rd),
    .o_tlb_wr(o_tlb_wr),
    .o_tlb_src_changed(o_tlb_src_changed),
    .o_status(o_status),
    .o_fetch_status(o_fetch_status),
    .o_hazard(o_hazard)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well above the roughly 160 cycles the tests need.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Presents one instruction; the next rising edge takes it.
  task automatic iss(input swv_op_t op, input logic [2:0] r, input logic [31:0] d,
                     input logic e);
    @(negedge i_clk);
    i_issue = '{1'b1, op, r, d, e};
  endtask

  // Fills with real no-operations, so they count as spacing instructions.
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_clk);
      i_issue = '{1'b1, SWV_OP_NOP, 3'h0, 32'h0000_0000, 1'b0};
    end
  endtask

  task automatic t_commit();
    iss(SWV_OP_MTC, 3'h3, 32'h1234_5670, 1'b0);
    idle(7);
    chk_w(o_status, 32'h0000_0000);
    chk_b(o_stall, 1'b0);
    idle(1);
    chk_w(o_status, 32'h1234_5670);
    $display("test commit done");
  endtask

  task automatic t_stall();
    iss(SWV_OP_MTC, 3'h3, 32'h0000_00a0, 1'b0);
    idle(3);
    i_gpr_busy = 1'b1;
    idle(1);
    chk_b(o_stall, 1'b1);
    idle(1);
    i_gpr_busy = 1'b0;
    idle(4);
    chk_w(o_status, 32'h1234_5670);
    idle(1);
    chk_w(o_status, 32'h0000_00a0);
    $display("test stall done");
  endtask

  task automatic t_read();
    iss(SWV_OP_MFC, 3'h3, 32'h0000_0000, 1'b0);
    idle(4);
    chk_b(o_rd.vld, 1'b0);
    idle(1);
    chk_b(o_rd.vld, 1'b1);
    chk_w(o_rd.data, 32'h0000_00a0);
    idle(1);
    chk_b(o_rd.vld, 1'b0);
    $display("test read done");
  endtask

  task automatic t_hazard(input swv_op_t op, input int gap, input logic exp,
                          input logic [31:0] wdat, input logic [31:0] rexp);
    iss(SWV_OP_MTC, 3'h0, wdat, 1'b0);
    idle(gap);
    iss(op, 3'h0, 32'h0000_0000, 1'b0);
    idle(3);
    chk_b(o_hazard, exp);
    idle(2);
    if (op == SWV_OP_MFC) begin
      chk_b(o_rd.vld, 1'b1);
      chk_w(o_rd.data, rexp);
    end
    idle(6);
    $display("test hazard done");
  endtask

  task automatic t_tlb();
    iss(SWV_OP_MTC, 3'h2, 32'h0000_4000, 1'b0);
    iss(SWV_OP_MTC, 3'h1, 32'h0000_0011, 1'b0);
    idle(8);
    iss(SWV_OP_MTC, 3'h1, 32'h0000_0022, 1'b0);
    iss(SWV_OP_TLB_WRITE_RANDOM, 3'h0, 32'h0000_0000, 1'b0);
    idle(8);
    chk_b(o_tlb_src_changed, 1'b1);
    chk_b(o_tlb_wr.vld, 1'b0);
    idle(1);
    chk_b(o_tlb_wr.vld, 1'b1);
    chk_w(o_tlb_wr.hi, 32'h0000_4000);
    chk_w(o_tlb_wr.lo, 32'h0000_0011);
    idle(1);
    chk_b(o_tlb_wr.vld, 1'b0);
    iss(SWV_OP_MTC, 3'h1, 32'h0000_0055, 1'b0);
    idle(1);
    iss(SWV_OP_TLB_WRITE_RANDOM, 3'h0, 32'h0000_0000, 1'b0);
    idle(9);
    chk_b(o_tlb_src_changed, 1'b0);
    chk_b(o_tlb_wr.vld, 1'b1);
    chk_w(o_tlb_wr.lo, 32'h0000_0055);
    $display("test tlb done");
  endtask

  task automatic t_exception_return();
    iss(SWV_OP_MTC, 3'h3, 32'h0000_0006, 1'b0);
    idle(8);
    iss(SWV_OP_EXCEPTION_RETURN, 3'h0, 32'h0000_0000, 1'b0);
    idle(3);
    chk_w(o_fetch_status, 32'h0000_0006);
    idle(3);
    chk_w(o_fetch_status, 32'h0000_0000);
    chk_w(o_status, 32'h0000_0006);
    idle(2);
    chk_w(o_status, 32'h0000_0006);
    idle(1);
    chk_w(o_status, 32'h0000_0000);
    $display("test exception_return done");
  endtask

  task automatic t_except();
    iss(SWV_OP_MTC, 3'h3, 32'h0000_0004, 1'b0);
    idle(8);
    iss(SWV_OP_EXCEPTION_RETURN, 3'h0, 32'h0000_1230, 1'b1);
    idle(9);
    chk_w(o_status, 32'h0000_0006);
    iss(SWV_OP_MFC, 3'h4, 32'h0000_0000, 1'b0);
    idle(5);
    chk_b(o_rd.vld, 1'b1);
    chk_w(o_rd.data, 32'h0000_1230);
    $display("test except done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_rst = 1'b1;
    i_gpr_busy = 1'b0;
    i_issue = '0;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    chk_w(o_status, 32'h0000_0000);
    chk_w(o_fetch_status, 32'h0000_0000);
    chk_b(o_rd.vld | o_tlb_wr.vld | o_hazard | o_stall | o_tlb_src_changed, 1'b0);
    t_commit();
    t_stall();
    t_read();
    t_hazard(SWV_OP_MFC, 1, 1'b1, 32'h0000_0011, 32'h0000_0000);
    t_hazard(SWV_OP_MFC, 2, 1'b0, 32'h0000_0022, 32'h0000_0022);
    t_hazard(SWV_OP_TLB_WRITE_RANDOM, 0, 1'b1, 32'h0000_0033, 32'h0000_0000);
    t_hazard(SWV_OP_TLB_WRITE_RANDOM, 1, 1'b0, 32'h0000_0044, 32'h0000_0000);
    t_tlb();
    t_exception_return();
    t_except();
    final_report();
  end
endmodule
